// *** hdl/rung_pkg.sv ***
// shared types, decoders and constants for the rung evaluator
`default_nettype none
package rung_pkg;
    localparam int          STACK_LEVELS = 8;
    localparam int          ADDR_W       = 16;
    localparam int          WORD_W       = 16;
    localparam int          BIT_IDX_W    = 4;
    localparam logic [15:0] ADDR_RST     = 16'h0000;
    localparam logic [15:0] WORD_RST     = 16'h0000;
    localparam logic [3:0]  BIT_IDX_RST  = 4'h0;
    localparam int          MEM_LATENCY  = 1;

    typedef enum logic [4:0] {
        NO_OPERATION            = 5'h00,
        PUSH_OPEN_CONTACT       = 5'h01,
        PUSH_CLOSED_CONTACT     = 5'h02,
        PUSH_OPEN_WORD_BIT      = 5'h03,
        PUSH_CLOSED_WORD_BIT    = 5'h04,
        SERIES_OPEN_CONTACT     = 5'h05,
        SERIES_CLOSED_CONTACT   = 5'h06,
        SERIES_OPEN_WORD_BIT    = 5'h07,
        SERIES_CLOSED_WORD_BIT  = 5'h08,
        PARALLEL_OPEN_CONTACT   = 5'h09,
        PARALLEL_CLOSED_CONTACT = 5'h0A,
        PARALLEL_OPEN_WORD_BIT  = 5'h0B,
        PARALLEL_CLOSED_WORD_BIT = 5'h0C,
        PUSH_COMPARE            = 5'h0D,
        SERIES_COMPARE          = 5'h0E,
        PARALLEL_COMPARE        = 5'h0F,
        SERIES_JOIN_BRANCHES    = 5'h10,
        PARALLEL_JOIN_BRANCHES  = 5'h11,
        COIL_OUT                = 5'h12,
        INVERT_RUNG             = 5'h13,
        END_PROGRAM             = 5'h14
    } opcode_t;

    typedef enum logic [3:0] {
        ACT_NONE     = 4'h0,
        ACT_PUSH     = 4'h1,
        ACT_AND      = 4'h2,
        ACT_OR       = 4'h3,
        ACT_JOIN_AND = 4'h4,
        ACT_JOIN_OR  = 4'h5,
        ACT_COIL     = 4'h6,
        ACT_INVERT   = 4'h7,
        ACT_END      = 4'h8
    } action_t;

    typedef enum logic [1:0] {
        SRC_NONE     = 2'h0,
        SRC_POINT    = 2'h1,
        SRC_WORD_BIT = 2'h2,
        SRC_COMPARE  = 2'h3
    } source_t;

    typedef enum logic [1:0] {
        REL_EQ = 2'h0,
        REL_NE = 2'h1,
        REL_GE = 2'h2,
        REL_LT = 2'h3
    } relation_t;

    typedef enum logic [2:0] {
        S_READY = 3'h0,
        S_MEM   = 3'h1,
        S_IO    = 3'h2,
        S_EXEC  = 3'h3,
        S_HALT  = 3'h4
    } state_t;

    function automatic action_t action_of(input opcode_t op);
        case (op)
            PUSH_OPEN_CONTACT, PUSH_CLOSED_CONTACT, PUSH_OPEN_WORD_BIT,
            PUSH_CLOSED_WORD_BIT, PUSH_COMPARE: action_of = ACT_PUSH;
            SERIES_OPEN_CONTACT, SERIES_CLOSED_CONTACT, SERIES_OPEN_WORD_BIT,
            SERIES_CLOSED_WORD_BIT, SERIES_COMPARE: action_of = ACT_AND;
            PARALLEL_OPEN_CONTACT, PARALLEL_CLOSED_CONTACT,
            PARALLEL_OPEN_WORD_BIT, PARALLEL_CLOSED_WORD_BIT,
            PARALLEL_COMPARE: action_of = ACT_OR;
            SERIES_JOIN_BRANCHES:   action_of = ACT_JOIN_AND;
            PARALLEL_JOIN_BRANCHES: action_of = ACT_JOIN_OR;
            COIL_OUT:               action_of = ACT_COIL;
            INVERT_RUNG:            action_of = ACT_INVERT;
            END_PROGRAM:            action_of = ACT_END;
            default:                action_of = ACT_NONE;
        endcase
    endfunction

    function automatic source_t source_of(input opcode_t op);
        case (op)
            PUSH_OPEN_CONTACT, PUSH_CLOSED_CONTACT, SERIES_OPEN_CONTACT,
            SERIES_CLOSED_CONTACT, PARALLEL_OPEN_CONTACT,
            PARALLEL_CLOSED_CONTACT: source_of = SRC_POINT;
            PUSH_OPEN_WORD_BIT, PUSH_CLOSED_WORD_BIT, SERIES_OPEN_WORD_BIT,
            SERIES_CLOSED_WORD_BIT, PARALLEL_OPEN_WORD_BIT,
            PARALLEL_CLOSED_WORD_BIT: source_of = SRC_WORD_BIT;
            PUSH_COMPARE, SERIES_COMPARE,
            PARALLEL_COMPARE: source_of = SRC_COMPARE;
            default: source_of = SRC_NONE;
        endcase
    endfunction

    function automatic logic negated_of(input opcode_t op);
        case (op)
            PUSH_CLOSED_CONTACT, PUSH_CLOSED_WORD_BIT, SERIES_CLOSED_CONTACT,
            SERIES_CLOSED_WORD_BIT, PARALLEL_CLOSED_CONTACT,
            PARALLEL_CLOSED_WORD_BIT: negated_of = 1'b1;
            default: negated_of = 1'b0;
        endcase
    endfunction
endpackage
`default_nettype wire

// *** hdl/contact_if.sv ***
// operand and result bundle between evaluator and contact solver
`default_nettype none
interface contact_if;
    logic [15:0]          word;
    logic [3:0]           bit_idx;
    rung_pkg::source_t    src;
    rung_pkg::relation_t  rel;
    logic [15:0]          konst;
    logic                 negate;
    logic                 state;

    modport solver (
        input  word,
        input  bit_idx,
        input  src,
        input  rel,
        input  konst,
        input  negate,
        output state
    );
    modport user (
        output word,
        output bit_idx,
        output src,
        output rel,
        output konst,
        output negate,
        input  state
    );
endinterface
`default_nettype wire

// *** hdl/contact_solver.sv ***
// contact value from point, word bit or four-digit compare
`default_nettype none
module contact_solver (
    contact_if.solver port
);
    logic raw_state;
    logic cmp_state;
    logic eq;
    logic lt;

    // packed bcd digits order like plain binary, so raw compare is exact
    assign eq = (port.word == port.konst);                       // see RULE6
    assign lt = (port.word < port.konst);

    always_comb begin
        case (port.rel)
            rung_pkg::REL_EQ: cmp_state = eq;
            rung_pkg::REL_NE: cmp_state = ~eq;
            rung_pkg::REL_GE: cmp_state = ~lt;
            default:          cmp_state = lt;
        endcase
    end

    always_comb begin
        case (port.src)
            rung_pkg::SRC_POINT:    raw_state = port.word[0];
            rung_pkg::SRC_WORD_BIT: begin                   // see RULE13
                raw_state = port.word[port.bit_idx];
            end
            rung_pkg::SRC_COMPARE:  raw_state = cmp_state;
            default:                raw_state = 1'b0;
        endcase
    end

    assign port.state = raw_state ^ port.negate; // see RULE11 RULE12 RULE15
endmodule
`default_nettype wire

// *** hdl/boolean_rung_stack_evaluator.sv ***
// rung instruction evaluator with eight-level boolean stack
`default_nettype none
// How it works
// RULE1 - end instruction halts execution until the scan restarts
// RULE2 - intermediate results live in an eight-level boolean stack
// RULE3 - rung-start contact pushes its value, older levels shift down one
// RULE4 - series join ANDs top two levels, parallel join ORs them
// RULE5 - pushing beyond eight levels raises the overflow error
// RULE6 - compare contact tests two four-digit values: eq, ne, ge, lt
// RULE7 - immediate contacts and coils stall until the module access completes
// RULE8 - immediate input reads never touch the input image
// RULE9 - every immediate input instruction reads the module afresh
// RULE10 - immediate coil writes the module and also the image point
// RULE11 - open rung-start contact takes the referenced point value
// RULE12 - closed rung-start contact takes the inverted point value
// RULE13 - word-bit contacts pick bit 0..15, closed variants invert it
// RULE14 - parallel open contact ORs point into top of stack
// RULE15 - parallel closed contact ORs inverted point into top of stack
// RULE16 - parallel word-bit contact ORs selected bit into top of stack
// RULE17 - series open contact ANDs point into top of stack
// RULE18 - series contacts may continue a rung after a coil
// RULE19 - coil writes top of stack to its point, last write wins
// RULE20 - invert complements top of stack where it occurs
// RULE21 - join with under two levels flags error; new rung clears stack
module boolean_rung_stack_evaluator #(
    parameter int STACK_DEPTH = rung_pkg::STACK_LEVELS
) (
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 instr_valid,
    output var  logic                 instr_ready,
    input  wire rung_pkg::opcode_t    instr_op,
    input  wire logic                 instr_new_rung,
    input  wire logic                 instr_immediate,
    input  wire logic [15:0]          instr_addr,
    input  wire logic [3:0]           instr_bit_idx,
    input  wire rung_pkg::relation_t  instr_rel,
    input  wire logic [15:0]          instr_konst,
    input  wire logic                 scan_restart,
    output var  logic                 mem_rd_en,
    output var  logic [15:0]          mem_addr,
    input  wire logic [15:0]          mem_rd_data,
    output var  logic                 img_wr_en,
    output var  logic [15:0]          img_wr_addr,
    output var  logic                 img_wr_data,
    output var  logic                 io_req,
    output var  logic                 io_wr,
    output var  logic [15:0]          io_addr,
    output var  logic                 io_wr_data,
    input  wire logic                 io_ack,
    input  wire logic [15:0]          io_rd_data,
    output var  logic                 rung_state,
    output var  logic [$clog2(STACK_DEPTH+1)-1:0] stack_depth,
    output var  logic                 overflow_err,
    output var  logic                 underflow_err,
    output var  logic                 halted
);
    localparam int DEPTH_W = $clog2(STACK_DEPTH + 1);
    localparam logic [DEPTH_W-1:0] DEPTH_FULL = DEPTH_W'(STACK_DEPTH);
    localparam logic [DEPTH_W-1:0] DEPTH_ONE  = DEPTH_W'(1);
    localparam logic [DEPTH_W-1:0] DEPTH_TWO  = DEPTH_W'(2);

    rung_pkg::state_t     state_reg;
    rung_pkg::state_t     state_next;
    rung_pkg::opcode_t    op_reg;
    rung_pkg::relation_t  rel_reg;
    logic                 new_rung_reg;
    logic                 imm_reg;
    logic [15:0]          addr_reg;
    logic [3:0]           bit_reg;
    logic [15:0]          konst_reg;
    logic [15:0]          io_word_reg;
    logic [STACK_DEPTH-1:0] stack_reg;
    logic [STACK_DEPTH-1:0] stack_next;
    logic [DEPTH_W-1:0]   depth_reg;
    logic [DEPTH_W-1:0]   depth_next;
    logic                 ovf_set;
    logic                 unf_set;
    logic                 instr_ready_reg;
    logic                 mem_rd_en_reg;
    logic [15:0]          mem_addr_reg;
    logic                 img_wr_en_reg;
    logic [15:0]          img_wr_addr_reg;
    logic                 img_wr_data_reg;
    logic                 io_req_reg;
    logic                 io_wr_reg;
    logic [15:0]          io_addr_reg;
    logic                 io_wr_data_reg;
    logic                 overflow_err_reg;
    logic                 underflow_err_reg;
    logic                 halted_reg;

    // decode of the incoming and of the held instruction
    wire rung_pkg::action_t in_act = rung_pkg::action_of(instr_op);
    wire rung_pkg::source_t in_src = rung_pkg::source_of(instr_op);
    wire rung_pkg::action_t act    = rung_pkg::action_of(op_reg);
    wire accept       = instr_valid && instr_ready_reg;
    wire in_needs_io  = instr_immediate &&
                        (in_src == rung_pkg::SRC_POINT ||
                         in_act == rung_pkg::ACT_COIL);
    wire in_needs_mem = (in_src != rung_pkg::SRC_NONE) && !in_needs_io;
    wire exec         = (state_reg == rung_pkg::S_EXEC);
    wire exec_go      = exec && !scan_restart;
    wire top_bit      = stack_reg[0];
    wire second_bit   = stack_reg[1];
    wire [STACK_DEPTH-2:0] stack_low = stack_reg[STACK_DEPTH-2:0];
    wire join_ok      = (depth_reg >= DEPTH_TWO);
    wire coil_go      = exec_go && (act == rung_pkg::ACT_COIL);
    wire contact_val;

    contact_if cif ();
    // immediate point contacts see only the module word, never the image
    assign cif.word    = imm_reg ? io_word_reg : mem_rd_data;  // see RULE8
    assign cif.bit_idx = bit_reg;
    assign cif.src     = rung_pkg::source_of(op_reg);
    assign cif.rel     = rel_reg;
    assign cif.konst   = konst_reg;
    assign cif.negate  = rung_pkg::negated_of(op_reg);
    assign contact_val = cif.state;

    contact_solver u_solver (
        .port (cif.solver)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rung_pkg::S_READY: begin
                if (accept) begin
                    if (in_act == rung_pkg::ACT_END) begin
                        state_next = rung_pkg::S_HALT;        // see RULE1
                    end else if (in_needs_io) begin
                        state_next = rung_pkg::S_IO;
                    end else if (in_needs_mem) begin
                        state_next = rung_pkg::S_MEM;
                    end else begin
                        state_next = rung_pkg::S_EXEC;
                    end
                end
            end
            rung_pkg::S_MEM:  state_next = rung_pkg::S_EXEC;
            rung_pkg::S_IO: begin
                if (io_ack) begin
                    state_next = rung_pkg::S_EXEC;            // see RULE7
                end
            end
            rung_pkg::S_EXEC: state_next = rung_pkg::S_READY;
            default: begin
                if (scan_restart) begin
                    state_next = rung_pkg::S_READY;
                end
            end
        endcase
    end

    always_comb begin
        stack_next = stack_reg;
        depth_next = depth_reg;
        ovf_set    = 1'b0;
        unf_set    = 1'b0;
        if (scan_restart) begin
            stack_next = '0;
            depth_next = '0;
        end else if (exec) begin
            case (act)
                rung_pkg::ACT_PUSH: begin
                    if (new_rung_reg) begin
                        stack_next = STACK_DEPTH'(contact_val);   // see RULE21
                        depth_next = DEPTH_ONE;
                    end else begin
                        stack_next = {stack_low, contact_val};   // see RULE3
                        if (depth_reg == DEPTH_FULL) begin
                            ovf_set = 1'b1;                      // see RULE5
                        end else begin
                            depth_next = DEPTH_W'(depth_reg + DEPTH_ONE);
                        end
                    end
                end
                // series also continues a rung past a midline coil
                rung_pkg::ACT_AND: begin            // see RULE17 RULE18
                    stack_next[0] = top_bit & contact_val;
                end
                rung_pkg::ACT_OR: begin             // see RULE14 RULE16
                    stack_next[0] = top_bit | contact_val;
                end
                rung_pkg::ACT_JOIN_AND, rung_pkg::ACT_JOIN_OR: begin
                    if (join_ok) begin
                        stack_next = {1'b0, stack_reg[STACK_DEPTH-1:1]};
                        stack_next[0] = (act == rung_pkg::ACT_JOIN_AND) ?
                            (top_bit & second_bit) :
                            (top_bit | second_bit);              // see RULE4
                        depth_next = DEPTH_W'(depth_reg - DEPTH_ONE);
                    end else begin
                        unf_set = 1'b1;                          // see RULE21
                    end
                end
                rung_pkg::ACT_INVERT: stack_next[0] = ~top_bit;  // see RULE20
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= rung_pkg::S_READY;
            stack_reg <= '0;
            depth_reg <= '0;
        end else begin
            state_reg <= state_next;
            stack_reg <= stack_next;                             // see RULE2
            depth_reg <= depth_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            op_reg       <= rung_pkg::NO_OPERATION;
            rel_reg      <= rung_pkg::REL_EQ;
            new_rung_reg <= 1'b0;
            imm_reg      <= 1'b0;
            addr_reg     <= rung_pkg::ADDR_RST;
            bit_reg      <= rung_pkg::BIT_IDX_RST;
            konst_reg    <= rung_pkg::WORD_RST;
        end else if (accept) begin
            op_reg       <= instr_op;
            rel_reg      <= instr_rel;
            new_rung_reg <= instr_new_rung;
            imm_reg      <= in_needs_io;
            addr_reg     <= instr_addr;
            bit_reg      <= instr_bit_idx;
            konst_reg    <= instr_konst;
        end
    end

    // every immediate read latches a new module word
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            io_word_reg <= rung_pkg::WORD_RST;
        end else if (state_reg == rung_pkg::S_IO && io_ack) begin
            io_word_reg <= io_rd_data;                           // see RULE9
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            instr_ready_reg <= 1'b0;
            halted_reg      <= 1'b0;
            mem_rd_en_reg   <= 1'b0;
            mem_addr_reg    <= rung_pkg::ADDR_RST;
            io_req_reg      <= 1'b0;
            io_wr_reg       <= 1'b0;
            io_addr_reg     <= rung_pkg::ADDR_RST;
            io_wr_data_reg  <= 1'b0;
        end else begin
            instr_ready_reg <= (state_next == rung_pkg::S_READY);
            halted_reg      <= (state_next == rung_pkg::S_HALT);
            mem_rd_en_reg   <= accept && in_needs_mem;
            io_req_reg      <= (state_next == rung_pkg::S_IO);   // see RULE7
            if (accept) begin
                mem_addr_reg   <= instr_addr;
                io_wr_reg      <= (in_act == rung_pkg::ACT_COIL);
                io_addr_reg    <= instr_addr;
                io_wr_data_reg <= top_bit;
            end
        end
    end

    // plain and immediate coils both land in the image; later wins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            img_wr_en_reg     <= 1'b0;
            img_wr_addr_reg   <= rung_pkg::ADDR_RST;
            img_wr_data_reg   <= 1'b0;
            overflow_err_reg  <= 1'b0;
            underflow_err_reg <= 1'b0;
        end else begin
            img_wr_en_reg     <= coil_go;                    // see RULE19
            img_wr_addr_reg   <= addr_reg;
            img_wr_data_reg   <= top_bit;                        // see RULE10
            overflow_err_reg  <= !scan_restart && (overflow_err_reg | ovf_set);
            underflow_err_reg <= !scan_restart &&
                                 (underflow_err_reg | unf_set);
        end
    end

    assign instr_ready   = instr_ready_reg;
    assign mem_rd_en     = mem_rd_en_reg;
    assign mem_addr      = mem_addr_reg;
    assign img_wr_en     = img_wr_en_reg;
    assign img_wr_addr   = img_wr_addr_reg;
    assign img_wr_data   = img_wr_data_reg;
    assign io_req        = io_req_reg;
    assign io_wr         = io_wr_reg;
    assign io_addr       = io_addr_reg;
    assign io_wr_data    = io_wr_data_reg;
    assign rung_state    = top_bit;
    assign stack_depth   = depth_reg;
    assign overflow_err  = overflow_err_reg;
    assign underflow_err = underflow_err_reg;
    assign halted        = halted_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_end_halts: assert property ( // see RULE1
        accept && instr_op == rung_pkg::END_PROGRAM |=>
            (halted_reg && !instr_ready_reg && !mem_rd_en_reg)[*2])
        else $error("end instruction did not halt");
    chk_depth_bound: assert property ( // see RULE2
        depth_reg <= DEPTH_FULL)
        else $error("stack depth beyond eight");
    chk_push_shift: assert property ( // see RULE3
        exec_go && act == rung_pkg::ACT_PUSH && !new_rung_reg &&
        depth_reg < DEPTH_FULL |=>
            stack_reg[STACK_DEPTH-1:1] == $past(stack_low) &&
            depth_reg == DEPTH_W'($past(depth_reg) + DEPTH_ONE))
        else $error("push did not shift stack");
    chk_join_and: assert property ( // see RULE4
        exec_go && act == rung_pkg::ACT_JOIN_AND && join_ok |=>
            stack_reg[0] == ($past(top_bit) & $past(second_bit)) &&
            depth_reg == DEPTH_W'($past(depth_reg) - DEPTH_ONE))
        else $error("series join wrong");
    chk_stack_overflow: assert property ( // see RULE5
        exec_go && act == rung_pkg::ACT_PUSH && !new_rung_reg &&
        depth_reg == DEPTH_FULL |=> overflow_err_reg)
        else $error("overflow not flagged");
    chk_io_stall: assert property ( // see RULE7
        io_req_reg && !io_ack |=> io_req_reg && !instr_ready_reg)
        else $error("did not stall for module access");
    chk_imm_no_image: assert property ( // see RULE8
        exec_go && imm_reg && act != rung_pkg::ACT_COIL |=> !img_wr_en_reg)
        else $error("immediate read touched image");
    chk_imm_fresh_read: assert property ( // see RULE9
        accept && in_needs_io && in_act != rung_pkg::ACT_COIL |=>
            io_req_reg && !io_wr_reg)
        else $error("immediate input not read afresh");
    chk_imm_coil_image: assert property ( // see RULE10
        io_req_reg && io_ack && io_wr_reg |=> ##1
            img_wr_en_reg && img_wr_data_reg == io_wr_data_reg)
        else $error("immediate coil missed image");
    chk_coil_write: assert property ( // see RULE19
        exec_go && act == rung_pkg::ACT_COIL |=> img_wr_en_reg &&
            img_wr_data_reg == $past(top_bit) &&
            img_wr_addr_reg == $past(addr_reg))
        else $error("coil wrote wrong state");
    chk_invert_top: assert property ( // see RULE20
        exec_go && act == rung_pkg::ACT_INVERT |=>
            stack_reg[0] == !$past(top_bit))
        else $error("invert did not complement");
    chk_join_underflow: assert property ( // see RULE21
        exec_go && act == rung_pkg::ACT_JOIN_OR && !join_ok |=>
            underflow_err_reg && depth_reg == $past(depth_reg))
        else $error("join underflow not flagged");

    cov_parallel_join: cover property (
        exec_go && act == rung_pkg::ACT_JOIN_OR && join_ok);
    cov_overflow: cover property (!overflow_err_reg ##1 overflow_err_reg);
    cov_imm_coil: cover property (io_req_reg && io_ack && io_wr_reg);
    cov_halt: cover property (halted_reg ##1 !halted_reg);
endmodule
`default_nettype wire

// *** test/rung_io_model.sv ***
// memory and i/o module model on the far side of the evaluator
`default_nettype none
module rung_io_model (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        mem_rd_en,
    input  wire logic [15:0] mem_addr,
    output var  logic [15:0] mem_rd_data,
    input  wire logic        io_req,
    input  wire logic [2:0]  io_dly,
    input  wire logic [15:0] io_word,
    output var  logic        io_ack,
    output var  logic [15:0] io_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_reg;
    logic       fire;
    assign fire = io_req && !io_ack && wait_reg >= io_dly;
    // idle buses toggle so a stale sample never passes
    always_ff @(posedge ref_clk) begin
        mem_rd_data <= mem_rd_en ? mem_addr ^ 16'hA5C3 : ~mem_rd_data;
        io_rd_data  <= fire ? io_word : ~io_rd_data;
        io_ack      <= fire && !sys_rst;
        wait_reg    <= (io_req && !io_ack) ? wait_reg + 3'h1 : 3'h0;
    end
endmodule
`default_nettype wire

// *** test/boolean_rung_stack_evaluator_bench.sv ***
// random rung programs checked against a stack model
`default_nettype none
module boolean_rung_stack_evaluator_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, sys_rst = 1, instr_valid = 0, instr_new_rung = 0;
    logic instr_immediate = 0, scan_restart = 0, instr_ready, mem_rd_en;
    logic img_wr_en, img_wr_data, io_req, io_wr, io_wr_data, io_ack;
    logic rung_state, overflow_err, underflow_err, halted;
    logic [15:0] instr_addr = 0, instr_konst = 0, mem_addr, mem_rd_data;
    logic [15:0] img_wr_addr, io_addr, io_rd_data, io_word = 0;
    logic [3:0] instr_bit_idx = 0, stack_depth;
    logic [2:0] io_dly = 0;
    rung_pkg::opcode_t instr_op = rung_pkg::NO_OPERATION;
    rung_pkg::relation_t instr_rel = rung_pkg::REL_EQ;
    logic [31:0] seed = 32'h51C1D22D;
    logic [7:0] stk = 8'h00;
    int mismatches = 0, checks = 0, d = 0, cyc = 0, eo = 0, eu = 0;
    boolean_rung_stack_evaluator uut (.*);
    rung_io_model far (.*);
    always #2 ref_clk = ~ref_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic ok);
        checks++;
        if (!ok) begin
            mismatches++;
            $display("ERROR at %0t: output differs from model", $time);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // bounded wait: also leaves the end instruction hanging on purpose
    task automatic issue(output int ni, output int nio);
        ni = 0;
        nio = 0;
        instr_valid <= 1;
        @(posedge ref_clk);
        while (!instr_ready) @(posedge ref_clk);
        instr_valid <= 0;
        repeat (40) begin
            @(posedge ref_clk);
            ni += img_wr_en;
            nio += io_req && io_ack;
            if (img_wr_en) chk(img_wr_data === stk[0]);
            if (io_req && io_wr) chk(io_wr_data === stk[0]);
            if (io_req) chk(io_addr === instr_addr);
            if (img_wr_en) chk(img_wr_addr === instr_addr);
            if (instr_ready) break;
        end
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        int o, g, kd, ni, nio, rl;
        logic v;
        logic [15:0] w, k;
        logic [31:0] r;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 0;
        @(posedge ref_clk);
        for (int i = 0; i < 800; i++) begin
            r = rnd();
            o = d == 0 ? 1 + r[6:5] : r[4:0] % 20;
            w = rnd();
            k = r[8] ? w : rnd();
            rl = r[14:13];
            instr_op <= rung_pkg::opcode_t'(o[4:0]);
            instr_addr <= w ^ 16'hA5C3;
            instr_konst <= k;
            instr_bit_idx <= r[12:9];
            instr_rel <= rung_pkg::relation_t'(r[14:13]);
            instr_immediate <= r[15];
            instr_new_rung <= r[18:16] == 0;
            io_word <= rnd();
            io_dly <= r[22:20];
            issue(ni, nio);
            g = o == 0 ? 9 : o <= 12 ? (o - 1) / 4 : o - 13;
            kd = (o - 1) % 4;
            v = (kd >= 2 ? w[r[12:9]] : r[15] ? io_word[0] : w[0]) ^ kd[0];
            if (o >= 13) v = rl == 0 ? w == k : rl == 1 ? w != k :
                             rl == 2 ? w >= k : w < k;
            if (g == 0 && r[18:16] == 0) {stk, d} = 0;
            if (g == 0) eo |= d == 8;
            if (g == 0) stk = {stk[6:0], v};
            if (g == 0) d += d < 8;
            if (g == 1) stk[0] &= v;
            if (g == 2) stk[0] |= v;
            if ((g == 3 || g == 4) && d < 2) eu = 1;
            else if (g == 3 || g == 4) begin
                stk = {1'b0, stk[7:2], g == 3 ? &stk[1:0] : |stk[1:0]};
                d--;
            end
            if (g == 6) stk[0] = !stk[0];
            chk(ni == (g == 5));
            v = r[15] && (g == 5 || (g < 3 && o <= 12 && kd < 2));
            chk(nio == v);
            chk(rung_state === stk[0]);
            chk(stack_depth === d[3:0]);
            chk(overflow_err === eo[0] && underflow_err === eu[0]);
        end
        instr_op <= rung_pkg::END_PROGRAM;
        issue(ni, nio);
        chk(halted === 1'b1 && instr_ready === 1'b0);
        instr_op <= rung_pkg::INVERT_RUNG;
        instr_valid <= 1;
        repeat (5) @(posedge ref_clk);
        chk(instr_ready === 1'b0 && rung_state === stk[0]);
        instr_valid <= 0;
        scan_restart <= 1;
        @(posedge ref_clk);
        scan_restart <= 0;
        repeat (3) @(posedge ref_clk);
        chk(halted === 1'b0 && stack_depth === 4'h0);
        chk(overflow_err === 1'b0 && underflow_err === 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
